// ---- verilog/cior_pkg.sv ----
// Purpose: Shared constants for the configuration I/O RAM bank.
// Assumes: Byte-wide registers at 16-bit byte addresses; one system clock.
// Notes:   Table entries are indexed 0..CIOR_NREG-1; index order matches every array.
package cior_pkg;

    localparam int          CIOR_NREG  = 12;
    localparam int          CIOR_IDX_W = 4;

    // Sequential alias window bounds
    localparam logic [15:0] CIOR_ALIAS_LO = 16'h2000;
    localparam logic [15:0] CIOR_ALIAS_HI = 16'h20ff;
    localparam logic [15:0] CIOR_PRIM_LO  = 16'h2100;

    // Primary byte address of each entry
    localparam logic [15:0] CIOR_PRI [CIOR_NREG] = '{
        16'h2106, 16'h2107, 16'h2108, 16'h2109, 16'h210a, 16'h210b,
        16'h2456, 16'h2458, 16'h2502, 16'h251d, 16'h270b, 16'h2200};

    // Alias byte address (valid only where CIOR_HAS_ALIAS is set)
    localparam logic [15:0] CIOR_ALIAS [CIOR_NREG] = '{
        16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2004, 16'h2005,
        16'h2021, 16'h2023, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [CIOR_NREG-1:0] CIOR_HAS_ALIAS = 12'h0ff;

    // Bits that have storage; all others read zero
    localparam logic [7:0] CIOR_IMPL [CIOR_NREG] = '{
        8'hef, 8'h1f, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'hdf, 8'hd0, 8'h3f, 8'h0f, 8'h01, 8'hff};

    // Write-only bits; stored, but read as zero
    localparam logic [7:0] CIOR_WO [CIOR_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};

    // Values loaded on reset and on wake
    localparam logic [7:0] CIOR_RST [CIOR_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] CIOR_WK [CIOR_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Battery-backed entries: neither reset nor wake touches them
    localparam logic [CIOR_NREG-1:0] CIOR_NV = 12'h300;

    // Named entries
    localparam int          CIOR_IDX_EQU   = 0;
    localparam int          CIOR_IDX_DIO0  = 6;
    localparam int          CIOR_IDX_NV0   = 8;
    localparam int          CIOR_IDX_WO    = 11;

    // Field positions
    localparam int          CIOR_EQU_LSB   = 5;
    localparam int          CIOR_EEX_LSB   = 6;

    // Special-function register mirror of the pin-control entry
    localparam logic [7:0]  CIOR_SFR_DIO0  = 8'ha2;

    // Pin-mode encodings
    localparam logic [1:0]  CIOR_EEX_TWO_WIRE   = 2'h1;
    localparam logic [1:0]  CIOR_EEX_THREE_WIRE = 2'h2;

endpackage : cior_pkg

// ---- verilog/cior_pin_mux.sv ----
// Purpose: Steers general pins two and three between plain I/O and the EEPROM link.
// Assumes: Pin inputs are asynchronous to core_clk.
// Notes:   Outputs are registered, so a mode change reaches the pins one edge later.
`timescale 1ns/1ps
module cior_pin_mux (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] eeprom_pin_mode_select,
    input  wire logic       gpio_two_out,
    input  wire logic       gpio_two_oe,
    input  wire logic       gpio_three_out,
    input  wire logic       gpio_three_oe,
    input  wire logic       serial_eeprom_clock,
    input  wire logic       serial_eeprom_data_out,
    input  wire logic       serial_eeprom_data_oe,
    input  wire logic       general_io_pin_two_in,
    input  wire logic       general_io_pin_three_in,
    output logic            general_io_pin_two_out,
    output logic            general_io_pin_two_oe,
    output logic            general_io_pin_three_out,
    output logic            general_io_pin_three_oe,
    output logic            gpio_two_in,
    output logic            gpio_three_in,
    output logic            serial_eeprom_data_in
);

    logic       ee_sel;
    logic [1:0] meta;

    // Either serial mode takes both pins; the link shares one pin pair
    assign ee_sel = (eeprom_pin_mode_select == cior_pkg::CIOR_EEX_TWO_WIRE) ||
                    (eeprom_pin_mode_select == cior_pkg::CIOR_EEX_THREE_WIRE);

    // Output steering, clock on pin two and data on pin three
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            general_io_pin_two_out   <= 1'b0;
            general_io_pin_two_oe    <= 1'b0;
            general_io_pin_three_out <= 1'b0;
            general_io_pin_three_oe  <= 1'b0;
        end else if (ee_sel) begin
            general_io_pin_two_out   <= serial_eeprom_clock;    // R1 R2
            general_io_pin_two_oe    <= 1'b1;
            general_io_pin_three_out <= serial_eeprom_data_out; // R1 R2
            general_io_pin_three_oe  <= serial_eeprom_data_oe;
        end else begin
            general_io_pin_two_out   <= gpio_two_out;
            general_io_pin_two_oe    <= gpio_two_oe;
            general_io_pin_three_out <= gpio_three_out;
            general_io_pin_three_oe  <= gpio_three_oe;
        end
    end

    // Two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta          <= 2'h0;
            gpio_two_in   <= 1'b0;
            gpio_three_in <= 1'b0;
        end else begin
            meta          <= {general_io_pin_three_in, general_io_pin_two_in};
            gpio_two_in   <= meta[0];
            gpio_three_in <= meta[1];
        end
    end

    // Data input seen by the link, taken behind the second stage so the
    // first stage fans out to one flop only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_eeprom_data_in <= 1'b0;
        end else begin
            serial_eeprom_data_in <= gpio_three_in;
        end
    end

    property p_pin_mode;
        @(posedge core_clk) disable iff (!rst_n)
        (eeprom_pin_mode_select == cior_pkg::CIOR_EEX_TWO_WIRE)
            |=> (general_io_pin_two_out == $past(serial_eeprom_clock)) &&
                general_io_pin_two_oe &&
                (general_io_pin_three_out == $past(serial_eeprom_data_out));
    endproperty
    a_pin_mode: assert property (p_pin_mode) // R1
        else $error("pins two and three not carrying eeprom link in mode 01");

endmodule : cior_pin_mux

// ---- verilog/cior_bank.sv ----
// Purpose: Configuration I/O RAM bank with alias window, SFR mirror and pin steering.
// Assumes: Core accesses arrive on core_clk; wake and power events are core_clk pulses.
// Notes:   Battery-backed entries have no reset and survive reset, wake and backed power loss.
// Function
// R1 - Pin-mode 01 turns pins two, three serial
// R2 - Three-wire link shares same clock, data pins
// R3 - Reset restarts core, loads all defaults; the battery-backed entries keep their contents instead
// R4 - 0x2000 window aliases fields above 0x2100
// R5 - Unimplemented bits ignore writes, read zero
// R6 - Software writes zero to reserved bits
// R7 - Nonvolatile bits survive power loss with battery
// R8 - Write-only bits always read zero
// R9 - Writable bits take reset and wake values
// R10 - Some bits mirrored into SFR space
// R11 - Wake keeps nonvolatile contents intact
// R12 - Alias write visible next read elsewhere
// R13 - Single-cycle access, write effective next cycle
`timescale 1ns/1ps
module cior_bank (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_wr,
    input  wire logic [7:0]  cpu_wdata,
    output logic [7:0]       cpu_rdata,
    output logic             cpu_rvalid,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    input  wire logic        wake_pulse,
    input  wire logic        power_fail,
    input  wire logic        battery_present,
    output logic             core_restart,
    output logic [1:0]       eeprom_pin_mode_select,
    output logic [2:0]       meter_equation_select,
    input  wire logic        gpio_two_out,
    input  wire logic        gpio_two_oe,
    input  wire logic        gpio_three_out,
    input  wire logic        gpio_three_oe,
    input  wire logic        serial_eeprom_clock,
    input  wire logic        serial_eeprom_data_out,
    input  wire logic        serial_eeprom_data_oe,
    output logic             gpio_two_in,
    output logic             gpio_three_in,
    output logic             serial_eeprom_data_in,
    input  wire logic        general_io_pin_two_in,
    input  wire logic        general_io_pin_three_in,
    output logic             general_io_pin_two_out,
    output logic             general_io_pin_two_oe,
    output logic             general_io_pin_three_out,
    output logic             general_io_pin_three_oe
);

    localparam int N  = cior_pkg::CIOR_NREG;
    localparam int IW = cior_pkg::CIOR_IDX_W;

    // Entry index must be wide enough for the table
    if (N > (1 << IW)) begin : g_bad_idx_w
        $error("index width too small for entry count");
    end

    logic [7:0]    bank [N];
    logic          hit;
    logic [IW-1:0] idx;
    logic          sfr_hit;
    logic [N-1:0]  wr_en;
    logic [7:0]    wr_val [N];

    // Address decode: both the primary and the alias address select one entry
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if ((cpu_addr == cior_pkg::CIOR_PRI[i]) ||
                (cior_pkg::CIOR_HAS_ALIAS[i] && (cpu_addr == cior_pkg::CIOR_ALIAS[i]))) begin
                hit = 1'b1;                                         // R4 R10
                idx = IW'(i);
            end
        end
    end

    assign sfr_hit = (sfr_addr == cior_pkg::CIOR_SFR_DIO0);

    // Core port wins if it writes the mirrored entry in the same cycle as the SFR port
    always_comb begin
        for (int i = 0; i < N; i++) begin
            wr_val[i] = (cpu_wr && hit && (idx == IW'(i))) ? cpu_wdata : sfr_wdata;
            wr_en[i] = (cpu_wr && hit && (idx == IW'(i))) ||
                       (sfr_wr && sfr_hit && (i == cior_pkg::CIOR_IDX_DIO0)); // R10
        end
    end

    // One storage byte per entry; unimplemented positions are masked off
    // at write so they never hold a one. Reserved bits are stored as written,
    // software is expected to keep them zero.
    for (genvar g = 0; g < N; g++) begin : g_entry
        logic [7:0] q;
        if (cior_pkg::CIOR_NV[g]) begin : g_nv
            // No reset: battery-backed content must outlive reset and wake
            always_ff @(posedge core_clk) begin
                if (power_fail && !battery_present) begin
                    q <= '0;                                        // R7
                end else if (wr_en[g]) begin
                    q <= wr_val[g] & cior_pkg::CIOR_IMPL[g];        // R5 R6
                end
            end
        end else begin : g_vol
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    q <= cior_pkg::CIOR_RST[g] & cior_pkg::CIOR_IMPL[g]; // R3 R9
                end else if (wake_pulse) begin
                    q <= cior_pkg::CIOR_WK[g] & cior_pkg::CIOR_IMPL[g];  // R9 R11
                end else if (wr_en[g]) begin
                    q <= wr_val[g] & cior_pkg::CIOR_IMPL[g];        // R5 R13
                end
            end
        end
        assign bank[g] = q;
    end

    // Read port: one cycle, write-only and unmapped bits return zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata  <= 8'h00;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= cpu_rd;                                   // R13
            if (cpu_rd) begin
                cpu_rdata <= hit ? (bank[idx] & cior_pkg::CIOR_IMPL[idx] &
                                    ~cior_pkg::CIOR_WO[idx]) : 8'h00; // R5 R8 R12
            end
        end
    end

    // SFR mirror read, same latency as the core port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= sfr_hit ? (bank[cior_pkg::CIOR_IDX_DIO0] &
                                    cior_pkg::CIOR_IMPL[cior_pkg::CIOR_IDX_DIO0]) : 8'h00; // R10
        end
    end

    // Core restart strobe held while reset is asserted, released one edge after
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_restart <= 1'b1;                                   // R3
        end else begin
            core_restart <= 1'b0;
        end
    end

    // Field outputs registered here so every top output comes from a flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_pin_mode_select <= 2'h0;
            meter_equation_select  <= 3'h0;
        end else begin
            eeprom_pin_mode_select <=
                bank[cior_pkg::CIOR_IDX_DIO0][cior_pkg::CIOR_EEX_LSB +: 2]; // R1
            meter_equation_select  <=
                bank[cior_pkg::CIOR_IDX_EQU][cior_pkg::CIOR_EQU_LSB +: 3];
        end
    end

    // Pin steering between general I/O and the serial EEPROM link
    cior_pin_mux u_pin_mux (
        .core_clk                (core_clk),
        .rst_n                   (rst_n),
        .eeprom_pin_mode_select  (eeprom_pin_mode_select),
        .gpio_two_out            (gpio_two_out),
        .gpio_two_oe             (gpio_two_oe),
        .gpio_three_out          (gpio_three_out),
        .gpio_three_oe           (gpio_three_oe),
        .serial_eeprom_clock     (serial_eeprom_clock),
        .serial_eeprom_data_out  (serial_eeprom_data_out),
        .serial_eeprom_data_oe   (serial_eeprom_data_oe),
        .general_io_pin_two_in   (general_io_pin_two_in),
        .general_io_pin_three_in (general_io_pin_three_in),
        .general_io_pin_two_out  (general_io_pin_two_out),
        .general_io_pin_two_oe   (general_io_pin_two_oe),
        .general_io_pin_three_out(general_io_pin_three_out),
        .general_io_pin_three_oe (general_io_pin_three_oe),
        .gpio_two_in             (gpio_two_in),
        .gpio_three_in           (gpio_three_in),
        .serial_eeprom_data_in   (serial_eeprom_data_in)
    );

    property p_alias_read;
        @(posedge core_clk) disable iff (!rst_n)
        (cpu_rd && (cpu_addr == cior_pkg::CIOR_ALIAS[0]))
            |=> (cpu_rdata == ($past(bank[0]) & cior_pkg::CIOR_IMPL[0]));
    endproperty
    a_alias_read: assert property (p_alias_read) // R4
        else $error("alias read differs from stored field");

    property p_unmapped;
        @(posedge core_clk) disable iff (!rst_n)
        (cpu_rd && !hit) |=> (cpu_rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) // R5
        else $error("unmapped read returned nonzero");

    property p_wo_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (cpu_rd && (cpu_addr == cior_pkg::CIOR_PRI[cior_pkg::CIOR_IDX_WO]))
            |=> ((cpu_rdata & cior_pkg::CIOR_WO[cior_pkg::CIOR_IDX_WO]) == 8'h00);
    endproperty
    a_wo_zero: assert property (p_wo_zero) // R8
        else $error("write-only bit read back nonzero");

    property p_wr_next;
        @(posedge core_clk) disable iff (!rst_n)
        (cpu_wr && (cpu_addr == cior_pkg::CIOR_PRI[1]) && !wake_pulse)
            |=> (bank[1] == ($past(cpu_wdata) & cior_pkg::CIOR_IMPL[1]));
    endproperty
    a_wr_next: assert property (p_wr_next) // R13
        else $error("write not stored by next cycle");

    property p_rd_lat;
        @(posedge core_clk) disable iff (!rst_n)
        (cpu_rd |=> cpu_rvalid) and (!cpu_rd |=> !cpu_rvalid);
    endproperty
    a_rd_lat: assert property (p_rd_lat) // R13
        else $error("read answer not one cycle after request");

    property p_wake_load;
        @(posedge core_clk) disable iff (!rst_n)
        wake_pulse |=> (bank[0] == (cior_pkg::CIOR_WK[0] & cior_pkg::CIOR_IMPL[0]));
    endproperty
    a_wake_load: assert property (p_wake_load) // R9
        else $error("wake value not loaded");

    property p_nv_wake;
        @(posedge core_clk) disable iff (!rst_n)
        (wake_pulse && !power_fail && !wr_en[cior_pkg::CIOR_IDX_NV0])
            |=> $stable(bank[cior_pkg::CIOR_IDX_NV0]);
    endproperty
    a_nv_wake: assert property (p_nv_wake) // R11
        else $error("nonvolatile entry changed on wake");

    property p_nv_batt;
        @(posedge core_clk) disable iff (!rst_n)
        (power_fail && battery_present && !wr_en[cior_pkg::CIOR_IDX_NV0])
            |=> $stable(bank[cior_pkg::CIOR_IDX_NV0]);
    endproperty
    a_nv_batt: assert property (p_nv_batt) // R7
        else $error("backed nonvolatile entry lost on power fail");

    property p_alias_cross;
        @(posedge core_clk) disable iff (!rst_n)
        (cpu_wr && (cpu_addr == cior_pkg::CIOR_ALIAS[2]) && !wake_pulse)
            ##1 (!cpu_wr && !wake_pulse)
            ##1 (cpu_rd && (cpu_addr == cior_pkg::CIOR_PRI[2]) && !cpu_wr && !wake_pulse)
            |=> (cpu_rdata == $past(cpu_wdata, 3));
    endproperty
    a_alias_cross: assert property (p_alias_cross) // R12
        else $error("alias write not visible at primary address");

    property p_sfr_mirror;
        @(posedge core_clk) disable iff (!rst_n)
        (sfr_rd && sfr_hit) |=> (sfr_rdata == ($past(bank[cior_pkg::CIOR_IDX_DIO0]) &
                                 cior_pkg::CIOR_IMPL[cior_pkg::CIOR_IDX_DIO0]));
    endproperty
    a_sfr_mirror: assert property (p_sfr_mirror) // R10
        else $error("SFR mirror differs from stored entry");

endmodule : cior_bank

// ---- tb/cior_core_model.sv ----
// Purpose: Behavioural processor core that issues byte reads and writes to the bank.
// Assumes: Requests change on the falling edge and are sampled on the next rising edge.
// Notes:   Read data is taken one edge after the strobe edge, when the answer stands.
`timescale 1ns/1ps
module cior_core_model (
    input  wire logic        core_clk,
    input  wire logic [7:0]  cpu_rdata,
    input  wire logic        cpu_rvalid,
    input  wire logic [7:0]  sfr_rdata,
    output logic [15:0]      cpu_addr,
    output logic             cpu_rd,
    output logic             cpu_wr,
    output logic [7:0]       cpu_wdata,
    output logic [7:0]       sfr_addr,
    output logic             sfr_rd,
    output logic             sfr_wr,
    output logic [7:0]       sfr_wdata
);
    // Idle bus at time zero
    initial begin
        cpu_addr  = 16'h0000;
        cpu_rd    = 1'b0;
        cpu_wr    = 1'b0;
        cpu_wdata = 8'h00;
        sfr_addr  = 8'h00;
        sfr_rd    = 1'b0;
        sfr_wr    = 1'b0;
        sfr_wdata = 8'h00;
    end

    // One-cycle write strobe; callers keep reserved bits at zero
    task automatic write(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = 1'b1;
        @(negedge core_clk);
        cpu_wr    = 1'b0;
        cpu_wdata = ~d; // Stale data is not left looking valid
    endtask : write

    // Answer must stand one edge after the strobe; a late answer is reported as not ok
    task automatic read(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(negedge core_clk);
        cpu_addr = a;
        cpu_rd   = 1'b1;
        @(negedge core_clk);
        cpu_rd = 1'b0;
        ok     = (cpu_rvalid === 1'b1);
        d      = cpu_rdata;
    endtask : read

    // Mirror port write, same strobe timing as the core port
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge core_clk);
        sfr_wr    = 1'b0;
        sfr_wdata = ~d;
    endtask : sfr_write

    // Mirror port read; data registered on the strobe edge
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        d      = sfr_rdata;
    endtask : sfr_read
endmodule : cior_core_model

// ---- tb/config_io_ram_bank_tb.sv ----
// Purpose: Self-checking bench for the configuration bank through core, mirror and pins.
// Assumes: Both shared pins carry pull-ups; no long counts to shorten.
// Notes:   Battery-backed entries are only read after being written.
`timescale 1ns/1ps
module config_io_ram_bank_tb;
    logic        core_clk = 1'b0;
    logic        rst_n, wake_pulse, power_fail, battery_present;
    logic        gpio_two_out, gpio_two_oe, gpio_three_out, gpio_three_oe;
    logic        serial_eeprom_clock, serial_eeprom_data_out, serial_eeprom_data_oe;
    logic [15:0] cpu_addr;
    logic        cpu_rd, cpu_wr, cpu_rvalid, sfr_rd, sfr_wr, core_restart;
    logic [7:0]  cpu_wdata, cpu_rdata, sfr_addr, sfr_wdata, sfr_rdata, d;
    logic [1:0]  eeprom_pin_mode_select;
    logic [2:0]  meter_equation_select;
    logic        gpio_two_in, gpio_three_in, serial_eeprom_data_in;
    logic        pin_two_oe, pin_two_q, pin_three_oe, pin_three_q;
    wire  logic  pin_two_lvl, pin_three_lvl;
    int          num_errors = 0;
    int          tests_run = 0;
    int          i;

    always #25 core_clk = ~core_clk;

    // Pull-ups win whenever nobody drives the pin
    assign pin_two_lvl   = pin_two_oe ? pin_two_q : 1'b1;
    assign pin_three_lvl = pin_three_oe ? pin_three_q : 1'b1;

    cior_core_model u_cior_core_model (
        .core_clk(core_clk), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
        .sfr_rdata(sfr_rdata), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
        .cpu_wdata(cpu_wdata), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata));

    cior_bank u_cior_bank (
        .core_clk(core_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wake_pulse(wake_pulse),
        .power_fail(power_fail), .battery_present(battery_present),
        .core_restart(core_restart), .eeprom_pin_mode_select(eeprom_pin_mode_select),
        .meter_equation_select(meter_equation_select), .gpio_two_out(gpio_two_out),
        .gpio_two_oe(gpio_two_oe), .gpio_three_out(gpio_three_out),
        .gpio_three_oe(gpio_three_oe), .serial_eeprom_clock(serial_eeprom_clock),
        .serial_eeprom_data_out(serial_eeprom_data_out),
        .serial_eeprom_data_oe(serial_eeprom_data_oe), .gpio_two_in(gpio_two_in),
        .gpio_three_in(gpio_three_in), .serial_eeprom_data_in(serial_eeprom_data_in),
        .general_io_pin_two_in(pin_two_lvl), .general_io_pin_three_in(pin_three_lvl),
        .general_io_pin_two_out(pin_two_q), .general_io_pin_two_oe(pin_two_oe),
        .general_io_pin_three_out(pin_three_q), .general_io_pin_three_oe(pin_three_oe));

    // Count and report one comparison
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Read that must answer in one cycle with the expected byte
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic       ok;
        u_cior_core_model.read(a, v, ok);
        check({7'h00, ok}, 8'h01);
        check(v, exp);
    endtask : rd_chk

    // Serial modes hand both pins to the link; others leave them to plain I/O
    task automatic pin_mode(input logic [1:0] m);
        logic ser;
        ser = (m == cior_pkg::CIOR_EEX_TWO_WIRE) || (m == cior_pkg::CIOR_EEX_THREE_WIRE);
        u_cior_core_model.write(16'h2456, {m, 6'h00});
        @(negedge core_clk);
        check({6'h00, eeprom_pin_mode_select}, {6'h00, m});
        @(negedge core_clk);
        check({4'h0, pin_two_q, pin_two_oe, pin_three_q, pin_three_oe}, ser ? 8'h0d : 8'h02);
    endtask : pin_mode

    // Verdict and end of run
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        rst_n = 1'b0;
        wake_pulse = 1'b0;
        power_fail = 1'b0;
        battery_present = 1'b1;
        gpio_two_out = 1'b0;
        gpio_two_oe = 1'b0;
        gpio_three_out = 1'b1;
        gpio_three_oe = 1'b0;
        serial_eeprom_clock = 1'b1;
        serial_eeprom_data_out = 1'b0;
        serial_eeprom_data_oe = 1'b1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        check({7'h00, core_restart}, 8'h01);
        rst_n = 1'b1;
        @(negedge core_clk);
        check({7'h00, core_restart}, 8'h00);
        // Every volatile entry holds its default after reset
        for (i = 0; i < cior_pkg::CIOR_NREG; i++) begin
            if (!cior_pkg::CIOR_NV[i]) begin
                rd_chk(cior_pkg::CIOR_PRI[i],
                       cior_pkg::CIOR_RST[i] & cior_pkg::CIOR_IMPL[i] & ~cior_pkg::CIOR_WO[i]);
            end
        end
        // Alias and primary reach one field in both directions
        for (i = 0; i < 8; i++) begin
            u_cior_core_model.write(cior_pkg::CIOR_ALIAS[i], 8'hff);
            rd_chk(cior_pkg::CIOR_PRI[i],
                   cior_pkg::CIOR_IMPL[i] & ~cior_pkg::CIOR_WO[i]);
            u_cior_core_model.write(cior_pkg::CIOR_PRI[i], 8'h00);
            rd_chk(cior_pkg::CIOR_ALIAS[i], 8'h00);
        end
        u_cior_core_model.write(16'h2000, 8'ha0);
        @(negedge core_clk);
        check({5'h00, meter_equation_select}, 8'h05);
        // Write-only bit reads zero; unmapped places hold nothing
        u_cior_core_model.write(16'h2200, 8'hff);
        rd_chk(16'h2200, 8'hf7);
        u_cior_core_model.write(16'h2110, 8'hff);
        rd_chk(16'h2110, 8'h00);
        u_cior_core_model.write(16'h2006, 8'hff);
        rd_chk(16'h2006, 8'h00);
        // Mirror port and the 0x2xxx places share the pin-control entry
        u_cior_core_model.sfr_write(cior_pkg::CIOR_SFR_DIO0, 8'h3f);
        rd_chk(16'h2456, 8'h1f);
        u_cior_core_model.write(16'h2021, 8'h11);
        u_cior_core_model.sfr_read(cior_pkg::CIOR_SFR_DIO0, d);
        check(d, 8'h11);
        u_cior_core_model.sfr_read(8'ha3, d);
        check(d, 8'h00);
        // All pin modes, then the input path in two-wire mode
        for (i = 0; i < 4; i++) begin
            pin_mode(2'(i));
        end
        pin_mode(cior_pkg::CIOR_EEX_TWO_WIRE);
        repeat (4) @(negedge core_clk);
        check({5'h00, gpio_two_in, gpio_three_in, serial_eeprom_data_in}, 8'h04);
        // Wake reloads volatile entries and spares battery-backed ones
        u_cior_core_model.write(16'h2502, 8'h3f);
        u_cior_core_model.write(16'h251d, 8'h0f);
        u_cior_core_model.write(16'h2106, 8'hef);
        @(negedge core_clk);
        wake_pulse = 1'b1;
        @(negedge core_clk);
        wake_pulse = 1'b0;
        rd_chk(16'h2502, 8'h3f);
        rd_chk(16'h251d, 8'h0f);
        rd_chk(16'h2106, cior_pkg::CIOR_WK[0] & cior_pkg::CIOR_IMPL[0]);
        // Power loss with a battery keeps the backed entries
        @(negedge core_clk);
        power_fail = 1'b1;
        @(negedge core_clk);
        power_fail = 1'b0;
        rd_chk(16'h2502, 8'h3f);
        // Reset in mid-run: restart, defaults, backed entries untouched
        u_cior_core_model.write(16'h2107, 8'h1f);
        @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        check({7'h00, core_restart}, 8'h01);
        rst_n = 1'b1;
        rd_chk(16'h2107, cior_pkg::CIOR_RST[1]);
        rd_chk(16'h251d, 8'h0f);
        // Power loss without a battery drops the backed entries
        @(negedge core_clk);
        battery_present = 1'b0;
        power_fail = 1'b1;
        @(negedge core_clk);
        power_fail = 1'b0;
        rd_chk(16'h251d, 8'h00);
        summarize();
    end
endmodule : config_io_ram_bank_tb
